// ==== core/pwr_clk_pkg.sv ====
// constants for the dual clock power mode controller
// assumes a 200 MHz fast clock and a slow oscillator arriving as a pin level
package pwr_clk_pkg;
	// register byte offsets on the axi4-lite bus
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] PORTG_OFS = 8'h04;
	localparam logic [7:0] INTCTL_OFS = 8'h08;
	localparam logic [7:0] IWIN_OFS = 8'h0c;
	localparam logic [7:0] STAT_OFS = 8'h10;
	// control register fields
	localparam int SLOW_ON_BIT = 0;
	localparam int FAST_ON_BIT = 1;
	localparam int DCE_BIT = 2;
	localparam int CCS_BIT = 3;
	localparam int SDLY_BIT = 4;
	// port g data bits
	localparam int IDLE_BIT = 6;
	localparam int HALT_BIT = 7;
	// interrupt control and status fields
	localparam int TIEN_BIT = 0;
	localparam int PEND_BIT = 0;
	localparam int MODE_LSB = 1;
	localparam int STATE_LSB = 4;
	// reset value of control: fast oscillator on, high speed mode
	localparam logic [4:0] CTRL_RST = 5'h02;
	// tick timer geometry: 32768 hz slow clock, 0.125 s window is bit 12
	localparam int TICK_W = 17;
	localparam int TAP_BASE = 12;
	localparam logic [2:0] WIN_MAX = 3'h4;
	localparam logic [TICK_W-1:0] STARTUP_LOAD = 17'h00100;
	// instruction cycle is five fast clocks
	localparam logic [2:0] INSTR_DIV = 3'h5;
	// axi responses
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// derived clock mode
	typedef enum logic [1:0] {
		MODE_HS = 2'h0,
		MODE_DUAL = 2'h1,
		MODE_LS = 2'h2
	} mode_t;
	// sequencer state, one-hot
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_HALT = 4'h2,
		ST_IDLE = 4'h4,
		ST_START = 4'h8
	} state_t;
endpackage

// ==== core/pwr_clk_ctrl.sv ====
// dual clock / low speed mode sequencer with halt, idle and tick timer
// assumes pins WAKE_I, SLOW_CLK_I, OSC_QUAL_I, HALT_DIS_I are asynchronous
`timescale 1ns/10ps
module pwr_clk_ctrl (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic WAKE_I,
	input wire logic SLOW_CLK_I,
	input wire logic OSC_QUAL_I,
	input wire logic HALT_DIS_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [7:0] AWADDR_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	output logic BVALID_O,
	input wire logic BREADY_I,
	output logic [1:0] BRESP_O,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	input wire logic [7:0] ARADDR_I,
	output logic RVALID_O,
	input wire logic RREADY_I,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic CORE_RUN_O,
	output logic CORE_SLOW_O,
	output logic FAST_OSC_EN_O,
	output logic SLOW_OSC_EN_O,
	output logic [1:0] MODE_O,
	output logic TICK_IRQ_O
);
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic wake_prev_r;
	logic slow_prev_r;
	logic wake_rise;
	logic slow_rise;
	logic [2:0] div_r;
	logic instr_tick;
	logic [4:0] ctrl_r;
	logic tien_r;
	logic [2:0] win_r;
	logic pend_r;
	logic halt_req_r;
	pwr_clk_pkg::state_t st_r;
	pwr_clk_pkg::mode_t mode;
	localparam int TICK_W_L = pwr_clk_pkg::TICK_W;
	localparam int TAP_BASE_L = pwr_clk_pkg::TAP_BASE;
	logic [TICK_W_L-1:0] tick_r;
	logic tick_step;
	logic sel_bit;
	logic sel_prev_r;
	logic sel_tog;
	logic core_step;
	logic aw_full_r;
	logic w_full_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic wstrb0_r;
	logic wr_en;
	logic wr_ok;
	logic rd_ok;
	logic [31:0] rd_data;

	// two-stage synchronisers for the asynchronous pins
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			wake_prev_r <= 1'b0;
			slow_prev_r <= 1'b0;
		end else begin
			sync1_r <= {HALT_DIS_I, OSC_QUAL_I, SLOW_CLK_I, WAKE_I};
			sync2_r <= sync1_r;
			wake_prev_r <= sync2_r[0];
			slow_prev_r <= sync2_r[1];
		end
	end
	assign wake_rise = sync2_r[0] && !wake_prev_r;
	assign slow_rise = sync2_r[1] && !slow_prev_r;

	// instruction cycle strobe, one fifth of the fast clock
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			div_r <= 3'h0;
		end else begin
			div_r <= (div_r == pwr_clk_pkg::INSTR_DIV - 3'h1) ? 3'h0 : div_r + 3'h1;
		end
	end
	assign instr_tick = (div_r == 3'h0);

	// clock mode from the control bits
	always_comb begin
		if (ctrl_r[pwr_clk_pkg::DCE_BIT] && ctrl_r[pwr_clk_pkg::CCS_BIT]) begin
			mode = pwr_clk_pkg::MODE_LS;
		end else if (ctrl_r[pwr_clk_pkg::DCE_BIT]) begin
			mode = pwr_clk_pkg::MODE_DUAL;
		end else begin
			mode = pwr_clk_pkg::MODE_HS;
		end
	end
	// the core advances on the slow clock in low speed mode
	assign core_step = (mode == pwr_clk_pkg::MODE_LS) ? slow_rise : instr_tick;

	// axi write path: address and data taken in either order
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0;
			wstrb0_r <= 1'b0;
			AWREADY_O <= 1'b1;
			WREADY_O <= 1'b1;
			BVALID_O <= 1'b0;
			BRESP_O <= pwr_clk_pkg::RESP_OK;
		end else begin
			if (AWVALID_I && AWREADY_O) begin
				aw_full_r <= 1'b1;
				awaddr_r <= AWADDR_I;
				AWREADY_O <= 1'b0;
			end
			if (WVALID_I && WREADY_O) begin
				w_full_r <= 1'b1;
				wdata_r <= WDATA_I;
				wstrb0_r <= WSTRB_I[0];
				WREADY_O <= 1'b0;
			end
			if (wr_en) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				BVALID_O <= 1'b1;
				BRESP_O <= wr_ok ? pwr_clk_pkg::RESP_OK : pwr_clk_pkg::RESP_SLVERR;
			end
			if (BVALID_O && BREADY_I) begin
				BVALID_O <= 1'b0;
				AWREADY_O <= 1'b1;
				WREADY_O <= 1'b1;
			end
		end
	end
	assign wr_en = aw_full_r && w_full_r && !BVALID_O;
	assign wr_ok = (awaddr_r == pwr_clk_pkg::CTRL_OFS) || (awaddr_r == pwr_clk_pkg::PORTG_OFS) ||
		(awaddr_r == pwr_clk_pkg::INTCTL_OFS) || (awaddr_r == pwr_clk_pkg::IWIN_OFS) ||
		(awaddr_r == pwr_clk_pkg::STAT_OFS);

	// control registers; all fields live in byte lane 0
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ctrl_r <= pwr_clk_pkg::CTRL_RST;
			tien_r <= 1'b0;
			win_r <= 3'h0;
		end else if (wr_en && wstrb0_r) begin
			if (awaddr_r == pwr_clk_pkg::CTRL_OFS) begin
				ctrl_r <= wdata_r[4:0];
			end
			if (awaddr_r == pwr_clk_pkg::INTCTL_OFS) begin
				tien_r <= wdata_r[pwr_clk_pkg::TIEN_BIT];
			end
			if (awaddr_r == pwr_clk_pkg::IWIN_OFS) begin
				win_r <= (wdata_r[2:0] > pwr_clk_pkg::WIN_MAX) ? pwr_clk_pkg::WIN_MAX : wdata_r[2:0];
			end
		end
	end

	// halt request waits for the next core step: the instruction cycle strobe, or the slow clock rise in low speed
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			halt_req_r <= 1'b0;
		end else if (wr_en && wstrb0_r && awaddr_r == pwr_clk_pkg::PORTG_OFS &&
			wdata_r[pwr_clk_pkg::HALT_BIT] && !sync2_r[3] && st_r == pwr_clk_pkg::ST_RUN) begin
			halt_req_r <= 1'b1;
		end else if (core_step || st_r != pwr_clk_pkg::ST_RUN) begin
			halt_req_r <= 1'b0;
		end
	end

	// power state sequencer
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			st_r <= pwr_clk_pkg::ST_RUN;
		end else begin
			case (st_r)
				pwr_clk_pkg::ST_RUN: begin
					if (halt_req_r && core_step) begin
						st_r <= pwr_clk_pkg::ST_HALT;
					end else if (wr_en && wstrb0_r && awaddr_r == pwr_clk_pkg::PORTG_OFS &&
						wdata_r[pwr_clk_pkg::IDLE_BIT] && !wdata_r[pwr_clk_pkg::HALT_BIT]) begin
						st_r <= pwr_clk_pkg::ST_IDLE;
					end
				end
				pwr_clk_pkg::ST_HALT: begin
					if (wake_rise) begin
						// low speed keeps its oscillator, so no delay there
						st_r <= (mode == pwr_clk_pkg::MODE_LS) ? pwr_clk_pkg::ST_RUN : pwr_clk_pkg::ST_START;
					end
				end
				pwr_clk_pkg::ST_IDLE: begin
					if (wake_rise || sel_tog) begin
						st_r <= pwr_clk_pkg::ST_RUN;
					end
				end
				pwr_clk_pkg::ST_START: begin
					if (tick_step && tick_r == TICK_W_L'(1)) begin
						st_r <= pwr_clk_pkg::ST_RUN;
					end
				end
				default: begin
					st_r <= pwr_clk_pkg::ST_RUN;
				end
			endcase
		end
	end

	// tick timer source: qualified instruction cycles during start-up,
	// nothing while halted, else the slow clock (instruction rate in high speed)
	always_comb begin
		case (st_r)
			pwr_clk_pkg::ST_START: tick_step = instr_tick && sync2_r[2];
			pwr_clk_pkg::ST_HALT: tick_step = 1'b0;
			default: tick_step = (mode == pwr_clk_pkg::MODE_HS) ? instr_tick : slow_rise;
		endcase
	end

	// tick timer, counting up but frozen in halt and counting down in start-up, invisible to software
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			tick_r <= '0;
		end else if (st_r == pwr_clk_pkg::ST_HALT && wake_rise && mode != pwr_clk_pkg::MODE_LS) begin
			tick_r <= pwr_clk_pkg::STARTUP_LOAD;
		end else if (tick_step) begin
			tick_r <= (st_r == pwr_clk_pkg::ST_START) ? tick_r - TICK_W_L'(1) : tick_r + TICK_W_L'(1);
		end
	end

	// window tap and its toggle detector
	assign sel_bit = tick_r[TAP_BASE_L + int'(win_r)];
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			sel_prev_r <= 1'b0;
		end else begin
			sel_prev_r <= sel_bit;
		end
	end
	assign sel_tog = (sel_bit != sel_prev_r) && st_r != pwr_clk_pkg::ST_START;

	// pending flag: write one clears it, a toggle in the same cycle wins
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			pend_r <= 1'b0;
		end else if (sel_tog) begin
			pend_r <= 1'b1;
		end else if (wr_en && wstrb0_r && awaddr_r == pwr_clk_pkg::STAT_OFS && wdata_r[pwr_clk_pkg::PEND_BIT]) begin
			pend_r <= 1'b0;
		end
	end

	// registered outputs toward the core and the oscillators
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			CORE_RUN_O <= 1'b1;
			CORE_SLOW_O <= 1'b0;
			FAST_OSC_EN_O <= 1'b1;
			SLOW_OSC_EN_O <= 1'b0;
			MODE_O <= pwr_clk_pkg::MODE_HS;
			TICK_IRQ_O <= 1'b0;
		end else begin
			CORE_RUN_O <= (st_r == pwr_clk_pkg::ST_RUN);
			CORE_SLOW_O <= (mode == pwr_clk_pkg::MODE_LS);
			FAST_OSC_EN_O <= ctrl_r[pwr_clk_pkg::FAST_ON_BIT] && st_r != pwr_clk_pkg::ST_HALT;
			SLOW_OSC_EN_O <= ctrl_r[pwr_clk_pkg::SLOW_ON_BIT] || mode == pwr_clk_pkg::MODE_LS;
			MODE_O <= mode;
			TICK_IRQ_O <= pend_r && tien_r;
		end
	end

	// read mux
	always_comb begin
		rd_data = 32'h0;
		rd_ok = 1'b1;
		case (ARADDR_I)
			pwr_clk_pkg::CTRL_OFS: rd_data[4:0] = ctrl_r;
			pwr_clk_pkg::PORTG_OFS: rd_data[7:6] = {halt_req_r || st_r == pwr_clk_pkg::ST_HALT, st_r == pwr_clk_pkg::ST_IDLE};
			pwr_clk_pkg::INTCTL_OFS: rd_data[0] = tien_r;
			pwr_clk_pkg::IWIN_OFS: rd_data[2:0] = win_r;
			pwr_clk_pkg::STAT_OFS: rd_data[7:0] = {st_r, 1'b0, mode, pend_r};
			default: rd_ok = 1'b0;
		endcase
	end

	// axi read path, one outstanding read
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ARREADY_O <= 1'b1;
			RVALID_O <= 1'b0;
			RDATA_O <= 32'h0;
			RRESP_O <= pwr_clk_pkg::RESP_OK;
		end else if (ARVALID_I && ARREADY_O) begin
			ARREADY_O <= 1'b0;
			RVALID_O <= 1'b1;
			RDATA_O <= rd_data;
			RRESP_O <= rd_ok ? pwr_clk_pkg::RESP_OK : pwr_clk_pkg::RESP_SLVERR;
		end else if (RVALID_O && RREADY_I) begin
			RVALID_O <= 1'b0;
			ARREADY_O <= 1'b1;
		end
	end

	// checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);

	a_halt_ignored: assert property (wr_en && wstrb0_r && awaddr_r == pwr_clk_pkg::PORTG_OFS && sync2_r[3]
		&& !halt_req_r |=> !halt_req_r) else $error("halt taken while disabled");
	a_halt_entry: assert property (halt_req_r && core_step && st_r == pwr_clk_pkg::ST_RUN
		|=> st_r == pwr_clk_pkg::ST_HALT ##1 !FAST_OSC_EN_O && !CORE_RUN_O) else $error("halt not entered");
	a_halt_frozen: assert property (st_r == pwr_clk_pkg::ST_HALT && !wake_rise |=> $stable(tick_r))
		else $error("tick moved in halt");
	a_wake_delay: assert property (st_r == pwr_clk_pkg::ST_HALT && wake_rise && mode != pwr_clk_pkg::MODE_LS
		|=> st_r == pwr_clk_pkg::ST_START && tick_r == pwr_clk_pkg::STARTUP_LOAD) else $error("no start-up load");
	a_delay_end: assert property (st_r == pwr_clk_pkg::ST_START && tick_step && tick_r == TICK_W_L'(1)
		|=> st_r == pwr_clk_pkg::ST_RUN && tick_r == '0) else $error("start-up end wrong");
	a_ls_fast_wake: assert property (st_r == pwr_clk_pkg::ST_HALT && wake_rise && mode == pwr_clk_pkg::MODE_LS
		|=> st_r == pwr_clk_pkg::ST_RUN ##1 CORE_RUN_O) else $error("low speed wake delayed");
	a_idle_exit: assert property (st_r == pwr_clk_pkg::ST_IDLE && sel_tog |=> st_r == pwr_clk_pkg::ST_RUN && pend_r)
		else $error("idle not ended by tick");
	a_irq_gate: assert property (pend_r && !tien_r |=> !TICK_IRQ_O) else $error("irq without enable");
	a_mode_out: assert property (!ctrl_r[pwr_clk_pkg::DCE_BIT] |=> MODE_O == pwr_clk_pkg::MODE_HS)
		else $error("mode not high speed");
	a_idle_entry: assert property (st_r == pwr_clk_pkg::ST_RUN && !(halt_req_r && core_step) && wr_en && wstrb0_r
		&& awaddr_r == pwr_clk_pkg::PORTG_OFS && wdata_r[7:6] == 2'h1 |=> st_r == pwr_clk_pkg::ST_IDLE)
		else $error("idle not entered");

	c_halt_wake: cover property (st_r == pwr_clk_pkg::ST_START ##1 st_r == pwr_clk_pkg::ST_RUN);
	c_idle_tick: cover property (st_r == pwr_clk_pkg::ST_IDLE && sel_tog);
	c_low_speed: cover property (mode == pwr_clk_pkg::MODE_LS && st_r == pwr_clk_pkg::ST_HALT);
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the dual clock power mode controller
// assumes pwr_clk_pkg and pwr_clk_ctrl are compiled first; the bench plays cpu and pins
`timescale 1ns/10ps
module tb;
	logic clk = 1'b0, nrst = 1'b0, wake = 1'b0, slow_clk = 1'b0, osc_qual = 1'b1, halt_dis = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	wire awready, wready, bvalid, arready, rvalid, core_run, core_slow, fast_en, slow_en, irq;
	wire [1:0] bresp, rresp, mode;
	wire [31:0] rdata;
	int error_cnt = 0, tests_run = 0, cyc = 0, sc = 0, n;
	logic [31:0] rd;
	logic [1:0] rsp;

	pwr_clk_ctrl pwr_clk_ctrl_i (.CLK_I(clk), .NRST_I(nrst), .WAKE_I(wake), .SLOW_CLK_I(slow_clk),
		.OSC_QUAL_I(osc_qual), .HALT_DIS_I(halt_dis), .AWVALID_I(awvalid), .AWREADY_O(awready),
		.AWADDR_I(awaddr), .WVALID_I(wvalid), .WREADY_O(wready), .WDATA_I(wdata), .WSTRB_I(wstrb),
		.BVALID_O(bvalid), .BREADY_I(bready), .BRESP_O(bresp), .ARVALID_I(arvalid), .ARREADY_O(arready),
		.ARADDR_I(araddr), .RVALID_O(rvalid), .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp),
		.CORE_RUN_O(core_run), .CORE_SLOW_O(core_slow), .FAST_OSC_EN_O(fast_en), .SLOW_OSC_EN_O(slow_en),
		.MODE_O(mode), .TICK_IRQ_O(irq));

	// 200 mhz fast clock
	initial begin
		forever #2.5 clk = ~clk;
	end

	// slow oscillator sped up to six fast cycles so a tick window fits the run
	always @(posedge clk) begin
		sc <= (sc == 5) ? 0 : sc + 1;
		slow_clk <= (sc < 3);
	end

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task wrap_up;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task chk_in(input string nm, input int lo, input int hi, input int v);
		tests_run++;
		if (v < lo || v > hi) begin
			error_cnt++;
			$display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, v);
		end
	endtask

	// axi4-lite write: address and data offered together, each dropped when taken
	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit done;
		done = 0;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				done = 1;
			end
		end
	endtask

	// axi4-lite read
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit done;
		done = 0;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1;
			end
		end
	endtask

	// write expecting okay, then let registered outputs settle
	task wrs(input logic [7:0] a, input logic [31:0] d);
		axi_wr(a, d, rsp);
		chk("bresp", pwr_clk_pkg::RESP_OK, rsp);
		repeat (2) @(posedge clk);
	endtask

	task wait_run(input logic lvl, input int lim, output int k);
		k = 0;
		while (core_run !== lvl && k < lim) begin
			@(posedge clk);
			k++;
		end
	endtask

	task pulse_wake;
		@(posedge clk) wake <= 1'b1;
		repeat (4) @(posedge clk);
		wake <= 1'b0;
	endtask

	task t_reset;
		chk("run", 1, core_run);
		chk("mode", 0, mode);
		chk("fast_en", 1, fast_en);
		chk("slow_en", 0, slow_en);
		chk("irq", 0, irq);
		axi_rd(pwr_clk_pkg::CTRL_OFS, rd, rsp);
		chk("ctrl", 32'h2, rd);
		axi_rd(pwr_clk_pkg::STAT_OFS, rd, rsp);
		chk("stat", 32'h10, rd);
		axi_wr(8'h20, 32'h5a, rsp);
		chk("bresp", pwr_clk_pkg::RESP_SLVERR, rsp);
		axi_rd(8'h20, rd, rsp);
		chk("rresp", pwr_clk_pkg::RESP_SLVERR, rsp);
		chk("rdata", 0, rd);
		$display("test reset done");
	endtask

	task t_modes;
		wrs(pwr_clk_pkg::CTRL_OFS, 32'h03);
		chk("mode", 0, mode);
		chk("slow_en", 1, slow_en);
		wrs(pwr_clk_pkg::CTRL_OFS, 32'h07);
		chk("mode", 1, mode);
		wrs(pwr_clk_pkg::CTRL_OFS, 32'h0f);
		chk("mode", 2, mode);
		chk("core_slow", 1, core_slow);
		wrs(pwr_clk_pkg::CTRL_OFS, 32'h0d);
		chk("fast_en", 0, fast_en);
		wrs(pwr_clk_pkg::PORTG_OFS, 32'h80);
		wait_run(0, 40, n);
		chk("run", 0, core_run);
		chk("slow_en", 1, slow_en);
		pulse_wake();
		wait_run(1, 40, n);
		chk("run", 1, core_run);
		wrs(pwr_clk_pkg::CTRL_OFS, 32'h0f);
		wrs(pwr_clk_pkg::CTRL_OFS, 32'h07);
		chk("mode", 1, mode);
		chk("core_slow", 0, core_slow);
		wrs(pwr_clk_pkg::CTRL_OFS, 32'h03);
		chk("mode", 0, mode);
		wrs(pwr_clk_pkg::CTRL_OFS, 32'h02);
		chk("slow_en", 0, slow_en);
		$display("test modes done");
	endtask

	task t_halt_dis;
		halt_dis <= 1'b1;
		repeat (4) @(posedge clk);
		wrs(pwr_clk_pkg::PORTG_OFS, 32'h80);
		repeat (20) @(posedge clk);
		chk("run", 1, core_run);
		halt_dis <= 1'b0;
		repeat (20) @(posedge clk);
		axi_rd(pwr_clk_pkg::STAT_OFS, rd, rsp);
		chk("state", 32'h10, rd & 32'hf0);
		$display("test halt disable done");
	endtask

	task t_halt_dual;
		wrs(pwr_clk_pkg::CTRL_OFS, 32'h07);
		osc_qual <= 1'b0;
		wrs(pwr_clk_pkg::PORTG_OFS, 32'h80);
		wait_run(0, 20, n);
		chk("run", 0, core_run);
		chk("fast_en", 0, fast_en);
		chk("slow_en", 1, slow_en);
		axi_rd(pwr_clk_pkg::STAT_OFS, rd, rsp);
		chk("state", 32'h20, rd & 32'hf0);
		pulse_wake();
		repeat (10) @(posedge clk);
		axi_rd(pwr_clk_pkg::STAT_OFS, rd, rsp);
		chk("state", 32'h80, rd & 32'hf0);
		// no qualified oscillator, so the delay must not advance
		repeat (300) @(posedge clk);
		chk("run", 0, core_run);
		osc_qual <= 1'b1;
		wait_run(1, 1400, n);
		chk_in("delay", 1270, 1300, n);
		$display("test dual halt done");
	endtask

	task t_halt_reset;
		wrs(pwr_clk_pkg::PORTG_OFS, 32'h80);
		wait_run(0, 20, n);
		chk("run", 0, core_run);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		chk("run", 1, core_run);
		chk("mode", 0, mode);
		axi_rd(pwr_clk_pkg::CTRL_OFS, rd, rsp);
		chk("ctrl", 32'h2, rd);
		$display("test halt reset done");
	endtask

	task t_idle_tick;
		wrs(pwr_clk_pkg::CTRL_OFS, 32'h07);
		wrs(pwr_clk_pkg::IWIN_OFS, 32'h7);
		axi_rd(pwr_clk_pkg::IWIN_OFS, rd, rsp);
		chk("iwin", 32'h4, rd);
		wrs(pwr_clk_pkg::IWIN_OFS, 32'h0);
		wrs(pwr_clk_pkg::INTCTL_OFS, 32'h1);
		wrs(pwr_clk_pkg::STAT_OFS, 32'h1);
		wrs(pwr_clk_pkg::PORTG_OFS, 32'h40);
		wait_run(0, 10, n);
		chk("run", 0, core_run);
		chk("fast_en", 1, fast_en);
		chk("slow_en", 1, slow_en);
		axi_rd(pwr_clk_pkg::STAT_OFS, rd, rsp);
		chk("state", 32'h40, rd & 32'hf0);
		// window 0 is 4096 slow ticks of six cycles
		wait_run(1, 24800, n);
		chk_in("idle len", 1, 24650, n);
		chk("irq", 1, irq);
		wrs(pwr_clk_pkg::INTCTL_OFS, 32'h0);
		chk("irq", 0, irq);
		axi_rd(pwr_clk_pkg::STAT_OFS, rd, rsp);
		chk("pend", 1, rd[0]);
		wrs(pwr_clk_pkg::STAT_OFS, 32'h1);
		axi_rd(pwr_clk_pkg::STAT_OFS, rd, rsp);
		chk("pend", 0, rd[0]);
		$display("test idle tick done");
	endtask

	task t_idle_wake;
		wrs(pwr_clk_pkg::PORTG_OFS, 32'h40);
		wait_run(0, 10, n);
		chk("run", 0, core_run);
		pulse_wake();
		wait_run(1, 20, n);
		chk("run", 1, core_run);
		$display("test idle wake done");
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_reset();
		t_modes();
		t_halt_dis();
		t_halt_dual();
		t_halt_reset();
		t_idle_tick();
		t_idle_wake();
		wrap_up();
	end
endmodule
